// File: wdog_pkg.sv
// Purpose: Shared constants and carriers for the frame-gated watchdog and idle control.
// Assumes: 10 MHz core clock; registers reached over the core's XDATA and SFR ports.
// Notes:   Every offset, field position and time lives here, plus the WDCS and general-purpose reset values.
package wdog_pkg;

  // Register addresses
  localparam logic [15:0] WDCS_XADDR        = 16'hFF93;
  localparam logic [7:0]  PWR_SFR_ADDR      = 8'h87;

  // Watchdog control/status fields
  localparam int          WD_ENABLE_BIT     = 7;
  localparam int          WD_CAUSE_BIT      = 6;
  localparam int          WD_RESTART_BIT    = 0;
  localparam logic [7:0]  WDCS_RESET        = 8'h00;

  // Power control fields
  localparam int          PWR_IDLE_BIT      = 0;
  localparam int          PWR_GP_LO         = 2;
  localparam int          PWR_GP_HI         = 3;
  localparam int          PWR_BAUD_BIT      = 7;
  localparam logic [1:0]  GP_RESET          = 2'h0;

  // Timing
  localparam int          CLK_HZ            = 10_000_000;
  localparam int          TICK_US           = 1000;
  localparam int          TICK_CYCLES       = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int          WD_TIMEOUT_MS     = 32;
  localparam int          WD_CNT_W          = 5;
  localparam int          WAKE_MIN_US       = 400;
  localparam int          WAKE_MIN_CYCLES   = (CLK_HZ / 1_000_000) * WAKE_MIN_US;

  // Processor-side register access, one cycle strobes
  typedef struct packed {
    logic        x_wr;
    logic        x_rd;
    logic [15:0] x_addr;
    logic        s_wr;
    logic        s_rd;
    logic [7:0]  s_addr;
    logic [7:0]  wdata;
  } reg_req_type;

  // Reset-source events from the chip reset logic
  typedef struct packed {
    logic power_up;
    logic usb_reset;
    logic usb_reset_en;
  } reset_evt_type;

endpackage : wdog_pkg

// File: wake_filter.sv
// Purpose: Qualifies the wake interrupt by a minimum asserted width.
// Assumes: Input synchronous to clk_in.
// Notes:   Emits one pulse per qualifying assertion.
`timescale 1ns/100ps
module wake_filter #(
  parameter int MIN_CYCLES = wdog_pkg::WAKE_MIN_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic level_in,
  output logic      qualified_out
);
  import wdog_pkg::*;

  localparam int CW = $clog2(MIN_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_CYCLES - 1);

  logic [CW-1:0] width_q;
  logic          done_q;
  logic          hit;

  // Count held width; a short glitch restarts the count
  assign hit = level_in && !done_q && (width_q == LAST);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      width_q       <= '0;
      done_q        <= 1'b0;
      qualified_out <= 1'b0;
    end else begin
      width_q       <= (level_in && !done_q) ? width_q + CW'(1) : '0;
      done_q        <= level_in && (done_q || hit);
      qualified_out <= hit;
    end
  end

  chk_wake_width : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    qualified_out |-> $past(level_in, 1) && $past(width_q, 1) == LAST)
    else $error("wake pulse without full width");

endmodule : wake_filter

// File: frame_gated_watchdog_idle.sv
// Purpose: Watchdog with control/status register plus processor power control.
// Assumes: Core register strobes last one cycle; frame_seen pulses on USB start-of-frame.
// Notes:   Outputs registered; mcu_reset_out is a one-cycle request.
//
// Operation
// - Watchdog counter advances once per 1 ms tick.
// - Watchdog stays inactive until a USB start-of-frame is seen.
// - Enabled watchdog resets the core after 32 ms without service.
// - Writing one to restart clears the 5-bit count; zero does nothing.
// - Restart bit reads back as zero.
// - Idle suspends the watchdog; a wake interrupt clears idle and resumes it.
// - Enable clears only on power-up or enabled USB reset.
// - Writing one to enable bit 7 starts the watchdog.
// - Cause flag bit 6 sets on timeout, clears on power-up, enabled USB reset or write-one.
// - Software sets idle bit 0; only interrupt-one logic clears it.
// - Wake needs interrupt-one held at least 400 us.
// - Idle stops oscillator, RAM low power, watchdog held.
// - Two general-purpose bits 3:2, read/write, reset to zero.
`timescale 1ns/100ps
module frame_gated_watchdog_idle #(
  parameter int TICK_CNT = wdog_pkg::TICK_CYCLES,
  parameter int WAKE_CNT = wdog_pkg::WAKE_MIN_CYCLES,
  parameter int CNT_W    = wdog_pkg::WD_CNT_W
) (
  input  wire logic                   clk_in,
  input  wire logic                   reset_n_in,
  input  wire wdog_pkg::reg_req_type  req_in,
  input  wire wdog_pkg::reset_evt_type rst_evt_in,
  input  wire logic                   frame_seen_in,
  input  wire logic                   ext_int_one_in,
  output logic [7:0]                  rdata_out,
  output logic                        mcu_reset_out,
  output logic                        osc_stop_out,
  output logic                        ram_low_power_out,
  output logic                        wake_int_out,
  output logic                        baud_double_out
);
  import wdog_pkg::*;

  localparam int TW = $clog2(TICK_CNT + 1);
  localparam logic [TW-1:0]    TICK_LAST = TW'(TICK_CNT - 1);
  localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(WD_TIMEOUT_MS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [TW-1:0]    tick_div_q;
  logic [CNT_W-1:0] watchdog_counter_q;
  logic             watchdog_enable_bit_q;
  logic             watchdog_reset_cause_flag_q;
  logic             processor_idle_bit_q;
  logic [1:0]       general_purpose_bits_q;
  logic             baud_q;
  logic             frame_armed_q;
  logic             wake;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wd_wr   = req_in.x_wr && (req_in.x_addr == WDCS_XADDR);
  wire wd_rd   = req_in.x_rd && (req_in.x_addr == WDCS_XADDR);
  wire pwr_wr  = req_in.s_wr && (req_in.s_addr == PWR_SFR_ADDR);
  wire pwr_rd  = req_in.s_rd && (req_in.s_addr == PWR_SFR_ADDR);
  wire hard_rst = rst_evt_in.power_up || (rst_evt_in.usb_reset && rst_evt_in.usb_reset_en);

  wire restart_wr = wd_wr && req_in.wdata[WD_RESTART_BIT];
  wire enable_wr  = wd_wr && req_in.wdata[WD_ENABLE_BIT];
  wire first_en   = enable_wr && !watchdog_enable_bit_q;
  // Idle freezes counting; no frame yet means not running either
  wire running    = watchdog_enable_bit_q && frame_armed_q && !processor_idle_bit_q;
  wire tick       = (tick_div_q == TICK_LAST);
  wire timeout    = running && tick && (watchdog_counter_q == CNT_LAST);

  wire [7:0] wd_view  = {watchdog_enable_bit_q, watchdog_reset_cause_flag_q, 6'h00};
  wire [7:0] pwr_view = {baud_q, 3'h0, general_purpose_bits_q, 1'b0, processor_idle_bit_q};

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualifier
  wake_filter #(.MIN_CYCLES(WAKE_CNT)) u_wake (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .level_in      (ext_int_one_in),
    .qualified_out (wake)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider; held at zero while idle since the oscillator is off
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) tick_div_q <= '0;
    else if (!running || tick) tick_div_q <= '0;
    else tick_div_q <= tick_div_q + TW'(1);
  end

  // Watchdog count
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) watchdog_counter_q <= '0;
    else if (restart_wr || first_en || timeout || hard_rst) watchdog_counter_q <= '0;
    else if (running && tick) watchdog_counter_q <= watchdog_counter_q + CNT_W'(1);
  end

  // Enable survives watchdog reset; frame gate re-arms after any reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      watchdog_enable_bit_q <= 1'b0;
      frame_armed_q         <= 1'b0;
    end else begin
      if (hard_rst) watchdog_enable_bit_q <= 1'b0;
      else if (enable_wr) watchdog_enable_bit_q <= 1'b1;
      if (hard_rst || timeout) frame_armed_q <= 1'b0;
      else if (frame_seen_in) frame_armed_q <= 1'b1;
    end
  end

  // Cause flag: timeout set wins over a software clear in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) watchdog_reset_cause_flag_q <= 1'b0;
    else if (timeout) watchdog_reset_cause_flag_q <= 1'b1;
    else if (hard_rst) watchdog_reset_cause_flag_q <= 1'b0;
    else if (wd_wr && req_in.wdata[WD_CAUSE_BIT]) watchdog_reset_cause_flag_q <= 1'b0;
  end

  // Power control; idle set by software, cleared only by the wake logic
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      processor_idle_bit_q   <= 1'b0;
      general_purpose_bits_q <= GP_RESET;
      baud_q                 <= 1'b0;
    end else begin
      if (wake) processor_idle_bit_q <= 1'b0;
      else if (pwr_wr && req_in.wdata[PWR_IDLE_BIT]) processor_idle_bit_q <= 1'b1;
      if (pwr_wr) begin
        general_purpose_bits_q <= req_in.wdata[PWR_GP_HI:PWR_GP_LO];
        baud_q                 <= req_in.wdata[PWR_BAUD_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out         <= 8'h00;
      mcu_reset_out     <= 1'b0;
      osc_stop_out      <= 1'b0;
      ram_low_power_out <= 1'b0;
      wake_int_out      <= 1'b0;
      baud_double_out   <= 1'b0;
    end else begin
      rdata_out         <= wd_rd ? wd_view : (pwr_rd ? pwr_view : 8'h00);
      mcu_reset_out     <= timeout;
      osc_stop_out      <= processor_idle_bit_q && !wake;
      ram_low_power_out <= processor_idle_bit_q && !wake;
      wake_int_out      <= wake && processor_idle_bit_q;
      baud_double_out   <= baud_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_service;
    restart_wr;
  endsequence

  chk_restart_clears : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_service |=> watchdog_counter_q == '0)
    else $error("restart did not clear count");
  chk_timeout_reset : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    timeout |=> mcu_reset_out && watchdog_reset_cause_flag_q)
    else $error("timeout did not reset core");
  chk_idle_freeze : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    processor_idle_bit_q && !restart_wr && !hard_rst |=> $stable(watchdog_counter_q))
    else $error("count moved in idle");
  chk_no_frame_hold : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !frame_armed_q |-> !timeout)
    else $error("timeout before frame");
  chk_enable_clear : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(watchdog_enable_bit_q) |-> $past(hard_rst))
    else $error("enable cleared without hard reset");
  chk_enable_set : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    enable_wr && !hard_rst |=> watchdog_enable_bit_q)
    else $error("enable write ignored");
  chk_restart_reads : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wd_rd |=> rdata_out[WD_RESTART_BIT] == 1'b0)
    else $error("restart bit read nonzero");
  chk_idle_exit : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(processor_idle_bit_q) |-> $past(wake))
    else $error("idle cleared without wake");
  chk_gp_write : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwr_wr |=> general_purpose_bits_q == $past(req_in.wdata[PWR_GP_HI:PWR_GP_LO]))
    else $error("general bits not written");
  chk_first_enable : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    first_en |=> watchdog_counter_q == '0)
    else $error("count not cleared on enable");
  chk_tick_period : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    running && $changed(watchdog_counter_q) && watchdog_counter_q != '0
      |-> $past(tick))
    else $error("count advanced off tick");
  chk_cause_clear : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hard_rst && !timeout |=> !watchdog_reset_cause_flag_q)
    else $error("cause flag not cleared");
  chk_idle_outputs : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    processor_idle_bit_q && !wake |=> osc_stop_out && ram_low_power_out)
    else $error("idle outputs not asserted");

  ////////////////////////////////////////////////////////////////////////////
  // Multi-step checks built from named sequences, plus the reset-source check
  sequence s_timeout_hit;
    timeout;
  endsequence

  // Reset request is a single-cycle pulse; a new timeout needs a fresh frame
  sequence s_reset_pulse;
    mcu_reset_out ##1 !mcu_reset_out;
  endsequence

  sequence s_wake_seen;
    processor_idle_bit_q && wake;
  endsequence

  // Idle drops at once, low-power outputs follow on the same edge and stay low
  sequence s_awake;
    !processor_idle_bit_q && !osc_stop_out ##1 !osc_stop_out;
  endsequence

  chk_reset_width : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_timeout_hit |=> s_reset_pulse)
    else $error("core reset not a single pulse");

  chk_reset_source : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mcu_reset_out |-> $past(timeout))
    else $error("core reset without timeout");

  chk_wake_sequence : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_wake_seen |=> s_awake)
    else $error("wake did not leave idle");

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources and enable
  chk_hard_count : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hard_rst |=> watchdog_counter_q == '0)
    else $error("count kept across hard reset");

  chk_hard_enable : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    hard_rst |=> !watchdog_enable_bit_q)
    else $error("enable kept across hard reset");

  chk_disabled_quiet : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !watchdog_enable_bit_q |-> !timeout)
    else $error("timeout while disabled");

  chk_frame_disarm : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    timeout |=> !frame_armed_q)
    else $error("frame gate kept after timeout");

  // Count may only move on a tick while running, or clear
  chk_stopped_count : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !running && !restart_wr && !first_en && !hard_rst |=> $stable(watchdog_counter_q))
    else $error("count moved while stopped");

  chk_divider_step : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    running && !tick |=> tick_div_q == $past(tick_div_q) + TW'(1))
    else $error("tick divider skipped");

  ////////////////////////////////////////////////////////////////////////////
  // Cause flag, where the hardware set must beat a software clear, and reserved read bits
  chk_cause_set_wins : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    timeout && wd_wr && req_in.wdata[WD_CAUSE_BIT] |=> watchdog_reset_cause_flag_q)
    else $error("software clear beat timeout");

  chk_cause_zero_write : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wd_wr && !req_in.wdata[WD_CAUSE_BIT] && !timeout && !hard_rst
      |=> $stable(watchdog_reset_cause_flag_q))
    else $error("zero write moved cause flag");

  chk_reserved_reads : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wd_rd |=> rdata_out[WD_CAUSE_BIT-1:WD_RESTART_BIT+1] == '0)
    else $error("reserved bits read nonzero");

  ////////////////////////////////////////////////////////////////////////////
  // Idle and power control
  chk_idle_set : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwr_wr && req_in.wdata[PWR_IDLE_BIT] && !wake |=> processor_idle_bit_q)
    else $error("idle write ignored");

  // Software cannot leave idle by writing zero
  chk_idle_hold : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    processor_idle_bit_q && !wake |=> processor_idle_bit_q)
    else $error("idle left without wake");

  chk_idle_no_timeout : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    processor_idle_bit_q |-> !timeout)
    else $error("timeout during idle");

  chk_idle_divider : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    processor_idle_bit_q |=> tick_div_q == '0)
    else $error("tick divider ran in idle");

  chk_wake_only_idle : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wake_int_out |-> !processor_idle_bit_q && $past(processor_idle_bit_q))
    else $error("wake pulse outside idle");

  chk_lowpower_pair : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    osc_stop_out == ram_low_power_out)
    else $error("low-power outputs disagree");

  chk_gp_reads : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwr_rd |=> rdata_out[PWR_GP_HI:PWR_GP_LO] == $past(general_purpose_bits_q))
    else $error("general bits read wrong");

  chk_idle_reads : assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwr_rd |=> rdata_out[PWR_IDLE_BIT] == $past(processor_idle_bit_q))
    else $error("idle bit read wrong");

endmodule : frame_gated_watchdog_idle

// File: core_model.sv
// Purpose: Core-side stand-in driving register strobes and interrupt one.
// Assumes: Everything changes 1 ns after the rising edge.
// Notes:   Released address and data lines carry the inverse of their last value; strobes go low.
`timescale 1ns/100ps
module core_model
  import wdog_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  output reg_req_type      req_out,
  output logic             int_one_out
);
  initial begin
    req_out     = '0;
    int_one_out = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One strobe per access; read data is taken one edge later
  task automatic access(input logic xd, input logic wr, input logic [15:0] addr,
                        input logic [7:0] data, output logic [7:0] rd);
    @(posedge clk_in);
    #1;
    req_out = '{xd & wr, xd & ~wr, addr, ~xd & wr, ~xd & ~wr, addr[7:0], data};
    @(posedge clk_in);
    #1;
    rd = rdata_in;
    // Stale lines must not look valid after release
    req_out = '{1'b0, 1'b0, ~addr, 1'b0, 1'b0, ~addr[7:0], ~data};
  endtask : access
  // Holds interrupt one high for n edges
  task automatic pulse(input int n);
    @(posedge clk_in);
    #1;
    int_one_out = 1'b1;
    repeat (n) @(posedge clk_in);
    #1;
    int_one_out = 1'b0;
  endtask : pulse
endmodule : core_model

// File: frame_gated_watchdog_idle_bench.sv
// Purpose: Self-checking bench for the watchdog and power control block.
// Assumes: Shortened tick and wake counts; core model drives the bus.
// Notes:   Timeout windows allow for tick divider phase.
`timescale 1ns/100ps
module frame_gated_watchdog_idle_bench;
  import wdog_pkg::*;
  localparam int T = 10;
  logic          clk_in = 0, reset_n_in = 0, frame_seen_in = 0, int_one;
  reset_evt_type rst_evt_in = '0;
  reg_req_type   req;
  logic [7:0]    rdata_out, rd, d;
  logic          mcu_reset_out, osc_stop_out, ram_low_power_out, wake_int_out, baud_double_out;
  int            bad_count = 0, comparisons = 0;
  always #50 clk_in = ~clk_in;
  frame_gated_watchdog_idle #(.TICK_CNT(T), .WAKE_CNT(4), .CNT_W(5)) DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .req_in(req), .rst_evt_in(rst_evt_in),
    .frame_seen_in(frame_seen_in), .ext_int_one_in(int_one), .rdata_out(rdata_out),
    .mcu_reset_out(mcu_reset_out), .osc_stop_out(osc_stop_out),
    .ram_low_power_out(ram_low_power_out), .wake_int_out(wake_int_out),
    .baud_double_out(baud_double_out));
  core_model core (.clk_in(clk_in), .rdata_in(rdata_out), .req_out(req), .int_one_out(int_one));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] wd_view(input logic en, input logic cause);
    return {en, cause, 6'h00};
  endfunction : wd_view
  function automatic logic [7:0] pw_view(input logic [7:0] w, input logic idle);
    return {w[7], 3'h0, w[3:2], 1'b0, idle};
  endfunction : pw_view
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic xw(input logic [7:0] v); core.access(1'b1, 1'b1, WDCS_XADDR, v, rd); endtask : xw
  task automatic pw(input logic [7:0] v);
    core.access(1'b0, 1'b1, {8'h00, PWR_SFR_ADDR}, v, rd);
  endtask : pw
  task automatic xchk(input logic [7:0] e);
    core.access(1'b1, 1'b0, WDCS_XADDR, 8'h00, rd);
    check(rd, e);
  endtask : xchk
  task automatic pchk(input logic [7:0] e);
    core.access(1'b0, 1'b0, {8'h00, PWR_SFR_ADDR}, 8'h00, rd);
    check(rd, e);
  endtask : pchk
  // No reset request may appear for n cycles
  task automatic quiet(input int n);
    logic hit;
    hit = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (mcu_reset_out === 1'b1) hit = 1;
    end
    check(hit, 8'h00);
  endtask : quiet
  // Bounded wait for a one-cycle pulse, sel 1 = wake, 0 = core reset
  task automatic wait_for(input logic sel, input int lo, input int hi);
    int n;
    n = 0;
    while ((sel ? wake_int_out : mcu_reset_out) !== 1'b1 && n <= hi) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(8'(n >= lo && n <= hi), 8'h01);
    if (n > hi) report_and_stop();
    @(posedge clk_in);
    #1;
    check(sel ? wake_int_out : mcu_reset_out, 8'h00);
  endtask : wait_for
  task automatic frame;
    @(posedge clk_in);
    #1 frame_seen_in = 1;
    @(posedge clk_in);
    #1 frame_seen_in = 0;
  endtask : frame
  task automatic evt(input logic [2:0] v);
    @(posedge clk_in);
    #1 rst_evt_in = v;
    @(posedge clk_in);
    #1 rst_evt_in = '0;
  endtask : evt
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(65));
    repeat (8) @(posedge clk_in);
    #1 reset_n_in = 1;
    xchk(8'h00);
    pchk(8'h00);
    core.access(1'b1, 1'b0, 16'hFF92, 8'h00, rd);
    check(rd, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'hFE;
      pw(d);
      pchk(pw_view(d, 1'b0));
      check(baud_double_out, d[7]);
    end
    xw(8'h81);
    xchk(wd_view(1'b1, 1'b0));
    quiet(40 * T);
    frame();
    for (int i = 0; i < 3; i++) begin
      quiet(($urandom % 28 + 1) * T);
      xw(8'h81);
    end
    quiet(20 * T);
    xw(8'h80);
    wait_for(1'b0, 10 * T, 12 * T + 4);
    xchk(wd_view(1'b1, 1'b1));
    xw(8'h80);
    xchk(wd_view(1'b1, 1'b1));
    xw(8'hC0);
    xchk(wd_view(1'b1, 1'b0));
    quiet(40 * T);
    // Idle holds the count; only a long interrupt wakes
    frame();
    quiet(10 * T);
    pw(8'h01);
    @(posedge clk_in);
    #1;
    check({osc_stop_out, ram_low_power_out}, 8'h03);
    pw(8'h00);
    pchk(pw_view(8'h00, 1'b1));
    quiet(50 * T);
    core.pulse(2);
    quiet(10);
    check(osc_stop_out, 8'h01);
    fork
      core.pulse(6);
      wait_for(1'b1, 3, 9);
    join
    check(osc_stop_out, 8'h00);
    wait_for(1'b0, 20 * T, 24 * T);
    evt(3'b010);
    xchk(wd_view(1'b1, 1'b1));
    evt(3'b011);
    xchk(8'h00);
    xw(8'hC0);
    evt(3'b100);
    xchk(8'h00);
    report_and_stop();
  end
endmodule : frame_gated_watchdog_idle_bench
